/* psc_defs.svh */
// offsets, field positions, reset values and timing counts for the phy status/control bank
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_OFF_EVT_A        8'h13
`define PSC_OFF_LOOP_PWR     8'h16
`define PSC_OFF_EVT_B        8'h18
`define PSC_OFF_STRAP        8'h19
`define PSC_OFF_TDR          8'h1E
`define PSC_OFF_RST          8'h1F
`define PSC_OFF_CFG          8'h11
`define PSC_OFF_INT_STAT     8'h20
`define PSC_OFF_INT_MASK     8'h21
`define PSC_EVT_A_RESET      16'h0000
`define PSC_EVT_B_RESET      16'h0008
`define PSC_CFG_RESET        16'h000A
`define PSC_BIT_PRBS_LOSS    10
`define PSC_BIT_CORE_PWR     8
`define PSC_BIT_PCS_DIG      7
`define PSC_BIT_ENERGY       10
`define PSC_BIT_TDR_START    15
`define PSC_BIT_TDR_AUTO     14
`define PSC_BIT_TDR_DONE     1
`define PSC_BIT_TDR_FAIL     0
`define PSC_BIT_FULL_RST     15
`define PSC_BIT_DIG_RST      14
`define PSC_BIT_RST_PIN_SRC  13
`define PSC_BIT_SR_NONCLEAR  6
`define PSC_BIT_INT_POL      3
`define PSC_BIT_FORCE_INT    2
`define PSC_BIT_INT_EN       1
`define PSC_EVT_A_RW_MASK    16'h00FF
`define PSC_EVT_B_RW_MASK    16'h00CF
`define PSC_CFG_RW_MASK      16'h004E
`define PSC_LOOP_RW_MASK     16'h00FF
`define PSC_RST_RW_MASK      16'h3FDF
`define PSC_RST_PULSE_NS     40
`define PSC_CLK_NS           10
`define PSC_RST_PULSE_CYC    ((`PSC_RST_PULSE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`endif

/* psc_pkg.sv */
// types shared by the phy status/control bank
package psc_pkg;
    // event inputs of one bank, order matches the status bits 15,14,11,10,9,8
    typedef struct packed {
        logic [5:0] ev;
    } psc_events_t;
    // signals from the core that the bank reports
    typedef struct packed {
        logic       prbs_lock_lost;
        logic       core_normal_pwr;
        logic       energy_detect;
        logic       link_down;
        logic       tdr_done;
        logic       tdr_fail;
    } psc_core_status_t;
    // controls that the bank drives into the core
    typedef struct packed {
        logic [6:0] loopback_mode;
        logic       pcs_dig_loopback;
        logic       tdr_start;
        logic       digital_reset;
        logic       full_chip_reset;
        logic       reset_pin_src_sw;
        logic [4:0] probe_module_sel;
        logic [4:0] probe_signal_sel;
    } psc_core_ctrl_t;
    // tdr launch sequence
    typedef enum logic [1:0] {
        PSC_TDR_IDLE = 2'b00,
        PSC_TDR_RUN  = 2'b01
    } psc_tdr_state_t;
endpackage

/* psc_event_bank.sv */
`timescale 1ns/1ns
// one bank of six sticky event flags with their enables
module psc_event_bank
    import psc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        soft_clr,
    input  wire psc_events_t events,
    input  wire logic        rd_clear,
    output logic [5:0]       flags,
    output logic             pending,
    input  wire logic [5:0]  enables
);
    // whole state of the bank
    typedef struct packed {
        logic [5:0] flags;
    } psc_bank_state_t;

    psc_bank_state_t st_reg;   // registered state
    psc_bank_state_t st_next;  // next state

    // sticky set wins over the read clear
    always_comb
    begin
        st_next = st_reg;
        if (rd_clear)
        begin
            st_next.flags = 6'h00;
        end
        st_next.flags = st_next.flags | events.ev;
        if (soft_clr)
        begin
            st_next.flags = 6'h00;
        end
    end

    // register the bank
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flags   = st_reg.flags;
    assign pending = |(st_reg.flags & enables);
endmodule

/* psc_regs.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// phy status and control register bank behind an apb slave
// Operation
// RQ1: bank A status flags, read only
// RQ2: bank A enables, reset zero, bits 5:4 writable
// RQ3: sticky prbs sync loss, write zero clears
// RQ4: bit 8 shows core normal power
// RQ5: one-hot loopback select plus pcs loopback bit
// RQ6: bank B status flags, read only
// RQ7: bank B enables, por enable resets one
// RQ8: strap address captured, read only field
// RQ9: energy detect status on bit 10
// RQ10: tdr start self clears, done/fail reported
// RQ11: auto tdr launch on link down
// RQ12: full reset clears logic and registers
// RQ13: digital reset keeps register contents
// RQ14: reset pin source from software bit
// RQ15: ten bit probe select split two fields
// RQ16: soft reset self clears unless configured
// RQ17: interrupt polarity follows config bit
// RQ18: interrupt on enabled flag and global enable
`include "psc_defs.svh"
module psc_regs
    import psc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire psc_events_t       events_a,
    input  wire psc_events_t       events_b,
    input  wire psc_core_status_t  core_status,
    input  wire logic [4:0]        strap_addr,
    output psc_core_ctrl_t         core_ctrl,
    output logic                   irq_pin
);
    // whole state of the bank in one struct
    typedef struct packed {
        logic [7:0]     en_a;         // bank A enables
        logic [7:0]     en_b;         // bank B enables
        logic           prbs_loss;    // sticky sync loss
        logic           pcs_dig;      // pcs digital loopback
        logic [6:0]     loop_mode;    // loopback select
        logic [4:0]     strap;        // captured address
        logic           strap_done;   // capture taken
        logic           tdr_start;    // measurement running
        logic           tdr_auto;     // auto launch enable
        logic           tdr_done;     // last done status
        logic           tdr_fail;     // last fail status
        logic           link_down_d;  // link down edge detect
        psc_tdr_state_t tdr_st;       // launch state
        logic           full_rst;     // full chip reset bit
        logic           dig_rst;      // digital reset bit
        logic           rst_pin_src;  // reset pin source
        logic [4:0]     probe_mod;    // probe module select
        logic [4:0]     probe_sig;    // probe signal select
        logic [1:0]     stby;         // plain r/w bits 7:6
        logic [3:0]     rst_cnt;      // reset pulse length
        logic [15:0]    cfg;          // polarity, enable, force, non-clear
        logic [1:0]     irq_stat;     // sticky bank summary
        logic [1:0]     irq_mask;     // summary mask
        logic [31:0]    rdata;        // read data
        logic           rd_ph;        // read answer cycle
    } psc_state_t;

    psc_state_t st_reg;   // registered state
    psc_state_t st_next;  // next state

    logic [5:0]  flags_a;   // bank A flags
    logic [5:0]  flags_b;   // bank B flags
    logic        pend_a;    // bank A enabled flag pending
    logic        pend_b;    // bank B enabled flag pending
    logic        acc;       // access phase
    logic        wr;        // write strobe
    logic        rd;        // read strobe
    logic [7:0]  reg_idx;   // register index
    logic        mapped;    // address decodes
    logic        clr_a;     // read clear of bank A
    logic        clr_b;     // read clear of bank B
    logic        full_clr;  // full reset of registers
    logic [15:0] wd;        // write data after strobes
    logic        rd_first;  // first cycle of a read access

    // register index from a byte address
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = 8'(a >> 2);
    endfunction

    // spread six flags onto status bits 15,14,11,10,9,8
    function automatic logic [15:0] flag_pos(input logic [5:0] f);
        flag_pos = {f[5], f[4], 2'b00, f[3:0], 8'h00};
    endfunction

    // access decode
    assign acc      = psel && penable;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    // read side effects fire once, in the first access cycle
    assign rd_first = rd && !st_reg.rd_ph;
    assign reg_idx  = word_idx(paddr);
    assign wd       = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
    assign full_clr = st_reg.full_rst;
    // flags clear at the edge that captures them
    assign clr_a    = rd_first && reg_idx == `PSC_OFF_EVT_A;
    assign clr_b    = rd_first && reg_idx == `PSC_OFF_EVT_B;

    // which indices exist
    always_comb
    begin
        unique case (reg_idx)
            `PSC_OFF_EVT_A, `PSC_OFF_LOOP_PWR, `PSC_OFF_EVT_B, `PSC_OFF_STRAP,
            `PSC_OFF_TDR, `PSC_OFF_RST, `PSC_OFF_CFG, `PSC_OFF_INT_STAT,
            `PSC_OFF_INT_MASK: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    // bank A event flags [RQ1]
    psc_event_bank u_bank_a (
        .pclk     (pclk),
        .presetn  (presetn),
        .soft_clr (full_clr),
        .events   (events_a),
        .rd_clear (clr_a),
        .flags    (flags_a),
        .pending  (pend_a),
        .enables  ({st_reg.en_a[7:6], st_reg.en_a[3:0]})
    );

    // bank B event flags [RQ6]
    psc_event_bank u_bank_b (
        .pclk     (pclk),
        .presetn  (presetn),
        .soft_clr (full_clr),
        .events   (events_b),
        .rd_clear (clr_b),
        .flags    (flags_b),
        .pending  (pend_b),
        .enables  ({st_reg.en_b[7:6], st_reg.en_b[3:0]})
    );

    // next-state logic: writes, hardware updates, read data
    always_comb
    begin
        st_next = st_reg;

        // strap capture once after reset release [RQ8]
        if (!st_reg.strap_done)
        begin
            st_next.strap      = strap_addr;
            st_next.strap_done = 1'b1;
        end

        // measurement sequencing; start clears on completion [RQ10]
        // ahead of writes, so a start in the finishing cycle wins
        unique case (st_reg.tdr_st)
            PSC_TDR_IDLE:
            begin
                if (st_reg.tdr_start)
                begin
                    st_next.tdr_st   = PSC_TDR_RUN;
                    st_next.tdr_done = 1'b0;
                    st_next.tdr_fail = 1'b0;
                end
            end
            PSC_TDR_RUN:
            begin
                if (core_status.tdr_done)
                begin
                    st_next.tdr_st    = PSC_TDR_IDLE;
                    st_next.tdr_start = 1'b0;
                    st_next.tdr_done  = 1'b1;
                    st_next.tdr_fail  = core_status.tdr_fail;
                end
            end
        endcase

        // register writes
        if (wr)
        begin
            unique case (reg_idx)
                `PSC_OFF_EVT_A:
                begin
                    st_next.en_a = wd[7:0];  // [RQ2]
                end
                `PSC_OFF_LOOP_PWR:
                begin
                    if (!wd[`PSC_BIT_PRBS_LOSS])
                        st_next.prbs_loss = 1'b0;  // write zero clears [RQ3]
                    st_next.pcs_dig   = wd[`PSC_BIT_PCS_DIG];  // [RQ5]
                    st_next.loop_mode = wd[6:0];  // [RQ5]
                end
                `PSC_OFF_EVT_B:
                begin
                    st_next.en_b = wd[7:0] & 8'(`PSC_EVT_B_RW_MASK);  // [RQ7]
                end
                `PSC_OFF_TDR:
                begin
                    st_next.tdr_auto = wd[`PSC_BIT_TDR_AUTO];  // [RQ11]
                    if (wd[`PSC_BIT_TDR_START])
                        st_next.tdr_start = 1'b1;  // [RQ10]
                end
                `PSC_OFF_RST:
                begin
                    if (wd[`PSC_BIT_FULL_RST])
                        st_next.full_rst = 1'b1;  // [RQ12]
                    st_next.dig_rst     = wd[`PSC_BIT_DIG_RST];  // writing zero ends it [RQ16]
                    st_next.rst_pin_src = wd[`PSC_BIT_RST_PIN_SRC];  // [RQ14]
                    st_next.probe_mod   = wd[12:8];  // [RQ15]
                    st_next.probe_sig   = wd[4:0];   // [RQ15]
                    st_next.stby        = wd[7:6];
                    if (wd[`PSC_BIT_DIG_RST])
                        st_next.rst_cnt = 4'(`PSC_RST_PULSE_CYC);
                end
                `PSC_OFF_CFG:
                begin
                    st_next.cfg = wd & `PSC_CFG_RW_MASK;
                end
                `PSC_OFF_INT_MASK:
                begin
                    st_next.irq_mask = wd[1:0];
                end
                default:
                begin
                end
            endcase
        end

        // sticky sync loss: set wins over write clear [RQ3]
        if (core_status.prbs_lock_lost)
            st_next.prbs_loss = 1'b1;

        // auto launch on falling link [RQ11]
        st_next.link_down_d = core_status.link_down;
        if (st_reg.tdr_auto && core_status.link_down && !st_reg.link_down_d)
            st_next.tdr_start = 1'b1;

        // digital reset pulse, self clearing unless non-clear set [RQ13] [RQ16]
        // any other write defers the self clear by one cycle
        if (st_reg.rst_cnt != 4'h0)
            st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
        else if (st_reg.dig_rst && !st_reg.cfg[`PSC_BIT_SR_NONCLEAR] && !wr)
            st_next.dig_rst = 1'b0;

        // sticky summary of the banks; set wins over read clear
        if (rd_first && reg_idx == `PSC_OFF_INT_STAT)
            st_next.irq_stat = 2'b00;
        st_next.irq_stat = st_next.irq_stat | {|flags_b, |flags_a};

        // read data, captured in the first access cycle
        // and answered from flops in the next one
        st_next.rd_ph = rd_first;
        st_next.rdata = 32'h0000_0000;
        if (rd_first)
        begin
            unique case (reg_idx)
                `PSC_OFF_EVT_A:    st_next.rdata[15:0] = flag_pos(flags_a) | {8'h00, st_reg.en_a};
                `PSC_OFF_LOOP_PWR: st_next.rdata[15:0] = {5'h00, st_reg.prbs_loss, 1'b0,
                                                         core_status.core_normal_pwr,  // [RQ4]
                                                         st_reg.pcs_dig, st_reg.loop_mode};
                `PSC_OFF_EVT_B:    st_next.rdata[15:0] = flag_pos(flags_b) | {8'h00, st_reg.en_b};
                `PSC_OFF_STRAP:    st_next.rdata[15:0] = {5'h00, core_status.energy_detect,  // [RQ9]
                                                         5'h00, st_reg.strap};
                `PSC_OFF_TDR:      st_next.rdata[15:0] = {st_reg.tdr_start, st_reg.tdr_auto, 12'h000,
                                                         st_reg.tdr_done, st_reg.tdr_fail};
                `PSC_OFF_RST:      st_next.rdata[15:0] = {st_reg.full_rst, st_reg.dig_rst, st_reg.rst_pin_src,
                                                         st_reg.probe_mod, st_reg.stby, 1'b0, st_reg.probe_sig};
                `PSC_OFF_CFG:      st_next.rdata[15:0] = st_reg.cfg;
                `PSC_OFF_INT_STAT: st_next.rdata[1:0]  = st_reg.irq_stat;
                `PSC_OFF_INT_MASK: st_next.rdata[1:0]  = st_reg.irq_mask;
                default:           st_next.rdata       = 32'h0000_0000;
            endcase
        end

        // full reset: registers back to reset values except strap, digital reset pulse raised, bit clears itself [RQ12]
        if (st_reg.full_rst)
        begin
            st_next             = '0;
            st_next.en_b        = 8'(`PSC_EVT_B_RESET);
            st_next.cfg         = `PSC_CFG_RESET;
            st_next.strap       = st_reg.strap;
            st_next.strap_done  = 1'b1;
            st_next.link_down_d = core_status.link_down;
            st_next.dig_rst     = 1'b1;
            st_next.rst_cnt     = 4'(`PSC_RST_PULSE_CYC);
        end
    end

    // register the whole state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg      <= '0;
            st_reg.en_b <= 8'(`PSC_EVT_B_RESET);
            st_reg.cfg  <= `PSC_CFG_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // apb answer: writes finish at once, reads wait one cycle
    // so that read data stands in flops when pready is high
    assign pready  = !rd || st_reg.rd_ph;
    assign pslverr = acc && pready && !mapped;
    assign prdata  = st_reg.rdata;

    // controls toward the core
    always_comb
    begin
        core_ctrl.loopback_mode    = st_reg.loop_mode;
        core_ctrl.pcs_dig_loopback = st_reg.pcs_dig;
        core_ctrl.tdr_start        = st_reg.tdr_start;
        core_ctrl.digital_reset    = st_reg.dig_rst;
        core_ctrl.full_chip_reset  = st_reg.full_rst;
        core_ctrl.reset_pin_src_sw = st_reg.rst_pin_src;
        core_ctrl.probe_module_sel = st_reg.probe_mod;
        core_ctrl.probe_signal_sel = st_reg.probe_sig;
    end

    // interrupt: enabled flags, global enable, force, mask, polarity [RQ17] [RQ18]
    logic irq_active;  // active-high request
    // pin idles high after reset, as polarity resets to active low
    assign irq_active = (st_reg.cfg[`PSC_BIT_INT_EN] &&
                         ((pend_a && st_reg.irq_mask[0]) || (pend_b && st_reg.irq_mask[1])))
                        || st_reg.cfg[`PSC_BIT_FORCE_INT];
    assign irq_pin = st_reg.cfg[`PSC_BIT_INT_POL] ? !irq_active : irq_active;
endmodule

/* psc_regs_properties.sv */
// port-level assertions for the phy status/control register bank
`timescale 1ns/1ns
module psc_regs_properties
    import psc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire psc_events_t       events_a,
    input wire psc_events_t       events_b,
    input wire psc_core_status_t  core_status,
    input wire logic [4:0]        strap_addr,
    input wire psc_core_ctrl_t    core_ctrl,
    input wire logic              irq_pin
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // completed write and read accesses
    logic wr_acc;
    logic rd_acc;
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && penable && pready && !pwrite;
    a_loop_write: assert property (wr_acc && paddr[7:0] == 8'h58 |=>
        core_ctrl.loopback_mode == $past(pwdata[6:0]) && core_ctrl.pcs_dig_loopback == $past(pwdata[7]))
        else $error("loopback controls do not follow the write");
    a_tdr_launch: assert property (wr_acc && paddr[7:0] == 8'h78 && pwdata[15] |=> core_ctrl.tdr_start)
        else $error("measurement start not raised");
    a_tdr_finish: assert property (core_ctrl.tdr_start && core_status.tdr_done |-> ##[1:2] !core_ctrl.tdr_start)
        else $error("measurement start not cleared on completion");
    a_probe_write: assert property (wr_acc && paddr[7:0] == 8'h7C && !pwdata[15] |=>
        core_ctrl.probe_module_sel == $past(pwdata[12:8]) && core_ctrl.probe_signal_sel == $past(pwdata[4:0]))
        else $error("probe selects do not follow the write");
    a_pin_source: assert property (wr_acc && paddr[7:0] == 8'h7C && !pwdata[15] |=>
        core_ctrl.reset_pin_src_sw == $past(pwdata[13]))
        else $error("reset pin source does not follow the write");
    a_dig_reset: assert property (wr_acc && paddr[7:0] == 8'h7C && pwdata[14] |-> ##[1:2] core_ctrl.digital_reset)
        else $error("digital reset not raised");
    a_full_reset: assert property (wr_acc && paddr[7:0] == 8'h7C && pwdata[15] |->
        ##[1:3] core_ctrl.loopback_mode == 7'h00 && core_ctrl.probe_module_sel == 5'h00)
        else $error("full reset left controls set");
    a_strap_read: assert property (rd_acc && paddr[7:0] == 8'h64 |->
        prdata[4:0] == strap_addr && prdata[10] == $past(core_status.energy_detect))
        else $error("strap address or energy flag wrong");
    a_power_read: assert property (rd_acc && paddr[7:0] == 8'h58 |-> prdata[8] == $past(core_status.core_normal_pwr))
        else $error("core power flag wrong");
    a_rsvd_read: assert property (rd_acc && paddr[7:0] == 8'h4C |-> prdata[13:12] == 2'b00)
        else $error("reserved status bits not zero");
endmodule

/* tb_top.sv */
// self-checking bench for the phy status/control register bank
`timescale 1ns/1ns
module tb_top
    import psc_pkg::*;
;
    logic             pclk;
    logic             presetn;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [3:0]       pstrb;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    psc_events_t      events_a;
    psc_events_t      events_b;
    psc_core_status_t core_status;
    logic [4:0]       strap_addr;
    psc_core_ctrl_t   core_ctrl;
    logic             irq_pin;
    int               fails;
    int               compares;
    logic             last_err;  // pslverr at the access edge
    logic [31:0]      rd_val;    // last read data
    int               bit_map [6] = '{8, 9, 10, 11, 14, 15};
    psc_regs #(.ADDR_W(12)) i_psc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events_a(events_a), .events_b(events_b), .core_status(core_status),
        .strap_addr(strap_addr), .core_ctrl(core_ctrl), .irq_pin(irq_pin));
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    // counted compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge pclk);
        end
        last_err = pslverr;
        rd_val = prdata;
        if (n >= 50)
            fails++;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd_val, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // one-cycle event on both banks
    task automatic pulse(input int i);
        @(posedge pclk);
        events_a.ev <= 6'h01 << i;
        events_b.ev <= 6'h01 << i;
        @(posedge pclk);
        events_a.ev <= 6'h00;
        events_b.ev <= 6'h00;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (6000) @(posedge pclk);
        fails++;
        give_verdict();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'h3;
        {events_a, events_b, core_status} = '0;
        strap_addr = 5'h15;
        {fails, compares, last_err, rd_val} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h13, 32'h0);
        rdc(8'h18, 32'h8);
        rdc(8'h16, 32'h0);
        rdc(8'h1E, 32'h0);
        rdc(8'h1F, 32'h0);
        rdc(8'h11, 32'hA);
        @(posedge pclk);
        core_status.energy_detect <= 1'b1;
        rdc(8'h19, 32'h415);
        rdc(8'h05, 32'h0);
        chk(last_err, 32'h1);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++)
        begin
            pulse(i);
            rdc(8'h13, 32'h1 << bit_map[i]);
            rdc(8'h18, (32'h1 << bit_map[i]) | 32'h8);
            rdc(8'h13, 32'h0);
        end
        wr(8'h13, 32'hFFFF_FFFF);
        rdc(8'h13, 32'hFF);
        wr(8'h18, 32'hFFFF_FFFF);
        rdc(8'h18, 32'hCF);
        wr(8'h18, 32'h8);
        $display("test events done");
        wr(8'h13, 32'h80);
        wr(8'h21, 32'h1);
        chk(irq_pin, 32'h1);
        pulse(5);
        cyc(2);
        chk(irq_pin, 32'h0);
        rdc(8'h13, 32'h8080);
        apb(1'b0, 8'h18, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd_val[0], 32'h1);
        cyc(2);
        chk(irq_pin, 32'h1);
        wr(8'h21, 32'h0);
        pulse(5);
        cyc(2);
        chk(irq_pin, 32'h1);
        apb(1'b0, 8'h13, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        wr(8'h11, 32'hE);
        chk(irq_pin, 32'h0);
        wr(8'h11, 32'h6);
        chk(irq_pin, 32'h1);
        wr(8'h11, 32'h2);
        chk(irq_pin, 32'h0);
        wr(8'h11, 32'hA);
        $display("test interrupt done");
        @(posedge pclk);
        core_status.prbs_lock_lost <= 1'b1;
        core_status.core_normal_pwr <= 1'b1;
        @(posedge pclk);
        core_status.prbs_lock_lost <= 1'b0;
        rdc(8'h16, 32'h500);
        rdc(8'h16, 32'h500);
        wr(8'h16, 32'h0);
        rdc(8'h16, 32'h100);
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h16, (32'h1 << i) | 32'h80);
            chk(core_ctrl.loopback_mode, 32'h1 << i);
            chk(core_ctrl.pcs_dig_loopback, 32'h1);
            rdc(8'h16, (32'h1 << i) | 32'h180);
        end
        $display("test loopback done");
        wr(8'h1F, 32'h3A15);
        chk(core_ctrl.probe_module_sel, 32'h1A);
        chk(core_ctrl.probe_signal_sel, 32'h15);
        chk(core_ctrl.reset_pin_src_sw, 32'h1);
        rdc(8'h1F, 32'h3A15);
        wr(8'h1F, 32'h4000);
        cyc(1);
        chk(core_ctrl.digital_reset, 32'h1);
        cyc(8);
        chk(core_ctrl.digital_reset, 32'h0);
        rdc(8'h1F, 32'h0);
        rdc(8'h16, 32'h190);
        wr(8'h11, 32'h4A);
        wr(8'h1F, 32'h4000);
        cyc(8);
        rdc(8'h1F, 32'h4000);
        wr(8'h1F, 32'h0);
        rdc(8'h1F, 32'h0);
        wr(8'h11, 32'hA);
        $display("test resets done");
        wr(8'h1E, 32'h8000);
        chk(core_ctrl.tdr_start, 32'h1);
        @(posedge pclk);
        core_status.tdr_done <= 1'b1;
        core_status.tdr_fail <= 1'b1;
        cyc(2);
        chk(core_ctrl.tdr_start, 32'h0);
        rdc(8'h1E, 32'h3);
        @(posedge pclk);
        core_status.tdr_done <= 1'b0;
        core_status.tdr_fail <= 1'b0;
        wr(8'h1E, 32'h4000);
        chk(core_ctrl.tdr_start, 32'h0);
        @(posedge pclk);
        core_status.link_down <= 1'b1;
        cyc(3);
        chk(core_ctrl.tdr_start, 32'h1);
        @(posedge pclk);
        core_status.tdr_done <= 1'b1;
        @(posedge pclk);
        core_status.tdr_done <= 1'b0;
        core_status.link_down <= 1'b0;
        $display("test reflectometry done");
        wr(8'h13, 32'h55);
        wr(8'h1F, 32'h8000);
        cyc(10);
        rdc(8'h13, 32'h0);
        rdc(8'h18, 32'h8);
        rdc(8'h16, 32'h100);
        rdc(8'h1E, 32'h0);
        rdc(8'h1F, 32'h0);
        rdc(8'h19, 32'h415);
        $display("test full_reset done");
        give_verdict();
    end
endmodule
bind psc_regs psc_regs_properties #(.ADDR_W(ADDR_W)) i_psc_regs_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events_a(events_a), .events_b(events_b),
    .core_status(core_status), .strap_addr(strap_addr), .core_ctrl(core_ctrl), .irq_pin(irq_pin));
